//--- hw/adc_ctrl_pkg.sv
// Purpose: shared constants for the converter control block
// Assumes: 125 MHz system clock, 8-bit command and control bytes
// Notes: field positions follow the command byte layout

package adc_ctrl_pkg;

  localparam int RES_W_DEF = 24;
  localparam int BYTE_W = 8;
  localparam int CLK_MHZ = 125;
  // Output update period of the conversion timebase, in microseconds
  localparam int T_ADC_US = 60200;
  localparam int CONV_CYC_DEF = T_ADC_US * CLK_MHZ;
  localparam logic [5:0] ONES_RESET = 6'h20;

  // Command byte fields
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_RS_HI = 5;
  localparam int CMD_RS_LO = 4;
  localparam int CMD_RW_BIT = 3;
  localparam logic [5:0] CMD_CREAD_ON = 6'h0f;
  localparam logic [5:0] CMD_CREAD_OFF = 6'h0e;

  // Register selects
  localparam logic [1:0] RS_STATUS = 2'h0;
  localparam logic [1:0] RS_MODE = 2'h1;
  localparam logic [1:0] RS_DATA = 2'h3;

  // Mode register
  localparam logic [7:0] MODE_POR = 8'h02;
  localparam int MD_HI_BIT = 7;
  localparam int MD_LO_BIT = 6;
  localparam int POL_BIT = 2;
  localparam logic [1:0] MD_CONT = 2'h0;
  localparam logic [1:0] MD_SINGLE = 2'h2;
  localparam logic [1:0] MD_PDN = 2'h3;

  // Status register
  localparam logic [7:0] STAT_FIXED = 8'h08;
  localparam int STAT_RDY_BIT = 7;
  localparam int STAT_WL_BIT = 2;

  typedef enum logic [1:0] {PH_COMM, PH_WR, PH_RD} phase_t;
  typedef enum logic [1:0] {CV_OFF, CV_SETTLE, CV_RUN} conv_t;

endpackage : adc_ctrl_pkg

//--- hw/adc_conv_readout.sv
// Purpose: conversion sequencing and serial result readout
// Assumes: host clocks sclk, data out on falling, sampled on rising edge
// Notes: sample_i is the filter output, two's complement of full scale
//
// Behaviour
// - Mode 10 powers up, converts once, then returns to shutdown.
// - A single conversion takes two update periods of the timebase.
// - Single mode drives ready line low when the result is stored.
// - After a read, ready stays high until a new conversion finishes.
// - Data register may be reread outside continuous read mode.
// - After power-up the block converts continuously without commands.
// - Every completion outside a data access drops ready status bit; pin follows when selected.
// - Host selects data read by command; result shifts out on sclk.
// - Ready line returns high once the result is fully read.
// - A result completing during a data access outside continuous read is discarded.
// - Command 001111xx enters continuous read mode.
// - Continuous read presents each result without a per-result command.
// - Continuous read gives each result once; ready high until next.
// - In continuous read, an unread or partial result is replaced by the new one at completion.
// - Command 001110xx while ready is low leaves continuous read.
// - Serial input watched in continuous read for exit and ones reset.
// - Unipolar coding is straight binary, zero to all ones.
// - Bipolar coding is offset binary, midscale is one then zeros.
// - Result word is 16 or 24 bits wide by variant.
// - Polarity select bit of the mode register chooses the coding.
// - Mode field: 00 continuous, 01 reserved, 10 single, 11 power-down.
// - Outside continuous read, every transaction starts with a command byte selecting register.
// - Ready goes high one cycle before the data register updates.
// - Thirty-two ones restore power-on values and await a command.

`timescale 1ns/1ps
`default_nettype none

module adc_conv_readout
  import adc_ctrl_pkg::*;
#(
  parameter int RES_W = adc_ctrl_pkg::RES_W_DEF,
  parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_CYC_DEF
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic cs_n_i,
  input wire logic [RES_W-1:0] sample_i,
  output logic dout_rdy_o,
  output logic dout_oe_o,
  output logic rdy_n_o,
  output logic cread_o,
  output logic shutdown_o
);
  import adc_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] din_s;
    logic [1:0] cs_s;
    phase_t ph;
    logic [1:0] tgt;
    logic [5:0] bits;
    logic [7:0] sin;
    logic [RES_W-1:0] sout;
    logic [7:0] mode;
    logic [RES_W-1:0] data;
    logic rdy;
    logic pend;
    logic cread;
    logic [5:0] ones;
    conv_t cv;
    logic [31:0] tmr;
    logic per;
    logic dout;
    logic oe;
    logic shdn;
  } st_t;

  localparam logic [31:0] TMR_LAST = 32'(CONV_CYCLES - 1);
  localparam logic [5:0] LEN_BYTE = 6'(BYTE_W);
  localparam logic [5:0] LEN_DATA = 6'(RES_W);
  localparam logic STAT_WL = (RES_W == RES_W_DEF);

  // Power-on values of all registers and the interface
  function automatic st_t por_f(input st_t s);
    st_t r;
    r = s;
    // Link clock idles high: no false rise after reset
    r.sclk_s = '1;
    r.dout = 1'b1;
    r.shdn = 1'b0;
    r.ph = PH_COMM;
    r.tgt = RS_STATUS;
    r.bits = '0;
    r.sin = '0;
    r.sout = '0;
    r.mode = MODE_POR;
    r.data = '0;
    r.rdy = 1'b1;
    r.pend = 1'b0;
    r.cread = 1'b0;
    r.ones = '0;
    r.cv = CV_SETTLE;
    r.tmr = '0;
    r.per = 1'b0;
    return r;
  endfunction : por_f

  st_t q;
  st_t n;
  logic rise;
  logic fall;
  logic sel;
  logic [7:0] b;
  logic byte_done;
  logic rd_end;
  logic done;
  logic mode_wr;
  logic cmd_on;
  logic cmd_off;
  logic ifrst;
  logic acc_data;
  logic [1:0] md;
  logic [7:0] stat;
  logic [RES_W-1:0] code;
  logic [5:0] rd_len;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    n = q;
    n.sclk_s = {q.sclk_s[1:0], sclk_i};
    n.din_s = {q.din_s[0], din_i};
    n.cs_s = {q.cs_s[0], cs_n_i};
    rise = q.sclk_s[1] & ~q.sclk_s[2];
    fall = ~q.sclk_s[1] & q.sclk_s[2];
    sel = ~q.cs_s[1];
    b = {q.sin[6:0], q.din_s[1]};
    byte_done = sel && rise && (q.bits[2:0] == 3'h7);
    rd_len = (q.tgt == RS_DATA) ? LEN_DATA : LEN_BYTE;
    rd_end = sel && rise && (q.ph == PH_RD) && (q.bits + 6'h01 == rd_len);
    md = q.mode[MD_HI_BIT:MD_LO_BIT];
    acc_data = (q.ph == PH_RD) && (q.tgt == RS_DATA);
    done = 1'b0;
    mode_wr = 1'b0;
    cmd_on = 1'b0;
    cmd_off = 1'b0;
    stat = STAT_FIXED;
    stat[STAT_RDY_BIT] = q.rdy;
    stat[STAT_WL_BIT] = STAT_WL;
    // Unipolar straight binary, bipolar offset binary
    if (q.mode[POL_BIT])
    begin
      if (sample_i[RES_W-1])
        code = '0;
      else
        code = {sample_i[RES_W-2:0], sample_i[0]};
    end
    else
    begin
      code = {~sample_i[RES_W-1], sample_i[RES_W-2:0]};
    end

    // Conversion timebase
    case (q.cv)
      CV_OFF:
      begin
        n.tmr = '0;
      end
      default:
      begin
        if (q.tmr == TMR_LAST)
        begin
          n.tmr = '0;
          if (q.cv == CV_RUN || q.per)
          begin
            done = 1'b1;
            n.per = 1'b0;
            n.cv = (md == MD_SINGLE) ? CV_OFF : CV_RUN;
          end
          else
          begin
            n.per = 1'b1;
          end
        end
        else
        begin
          n.tmr = q.tmr + 32'h0000_0001;
        end
      end
    endcase

    // Serial interface
    if (!sel)
    begin
      n.bits = '0;
      if (!q.cread)
        n.ph = PH_COMM;
    end
    else
    begin
      if (rise)
      begin
        n.sin = b;
        n.bits = q.bits + 6'h01;
      end
      // MSB stands until the first rise has taken it
      if (fall && q.ph == PH_RD && q.bits != 6'h00)
        n.sout = {q.sout[RES_W-2:0], 1'b0};
      if (q.cread && byte_done)
      begin
        n.bits = (q.ph == PH_RD) ? q.bits + 6'h01 : '0;
        if (b[7:2] == CMD_CREAD_OFF && !q.rdy)
        begin
          cmd_off = 1'b1;
          n.cread = 1'b0;
          n.ph = PH_COMM;
          n.bits = '0;
        end
      end
      else if (byte_done && q.ph == PH_COMM && !b[CMD_WEN_BIT])
      begin
        n.bits = '0;
        n.tgt = b[CMD_RS_HI:CMD_RS_LO];
        if (b[7:2] == CMD_CREAD_ON)
        begin
          cmd_on = 1'b1;
          n.cread = 1'b1;
        end
        else if (b[CMD_RW_BIT])
        begin
          n.ph = PH_RD;
          if (b[CMD_RS_HI:CMD_RS_LO] == RS_DATA)
            n.sout = q.data;
          else if (b[CMD_RS_HI:CMD_RS_LO] == RS_MODE)
            n.sout = {q.mode, {(RES_W-8){1'b0}}};
          else
            n.sout = {stat, {(RES_W-8){1'b0}}};
        end
        else if (b[CMD_RS_HI:CMD_RS_LO] == RS_MODE)
        begin
          n.ph = PH_WR;
        end
      end
      else if (byte_done && q.ph == PH_COMM)
      begin
        n.bits = '0;
      end
      else if (byte_done && q.ph == PH_WR)
      begin
        n.bits = '0;
        n.ph = PH_COMM;
        n.mode = b;
        mode_wr = 1'b1;
        n.tmr = '0;
        n.per = 1'b0;
        if (b[MD_HI_BIT:MD_LO_BIT] == MD_PDN)
          n.cv = CV_OFF;
        else if (b[MD_HI_BIT:MD_LO_BIT] == MD_SINGLE)
          n.cv = CV_SETTLE;
        else if (b[MD_HI_BIT:MD_LO_BIT] == MD_CONT)
          n.cv = CV_SETTLE;
      end
      if (rd_end)
      begin
        n.ph = PH_COMM;
        n.bits = '0;
        if (q.tgt == RS_DATA)
          n.rdy = 1'b1;
      end
    end

    // Result update: ready raised first, then stored
    if (done)
    begin
      n.pend = 1'b1;
      n.rdy = 1'b1;
    end
    if (q.pend)
    begin
      n.pend = 1'b0;
      if (q.cread)
      begin
        n.data = code;
        n.rdy = 1'b0;
        n.ph = PH_RD;
        n.tgt = RS_DATA;
        n.bits = '0;
        n.sout = code;
      end
      else if (!acc_data)
      begin
        n.data = code;
        n.rdy = 1'b0;
      end
    end

    // Interface reset on a run of ones
    ifrst = 1'b0;
    if (sel && rise)
    begin
      n.ones = q.din_s[1] ? q.ones + 6'h01 : '0;
      if (q.din_s[1] && (q.ones + 6'h01 == ONES_RESET))
        ifrst = 1'b1;
    end
    if (ifrst)
      n = por_f(n);

    n.dout = (n.ph == PH_RD) ? n.sout[RES_W-1] : n.rdy;
    n.oe = ~q.cs_s[1];
    n.shdn = (n.cv == CV_OFF);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= por_f('0);
    else
      q <= n;
  end

  assign dout_rdy_o = q.dout;
  assign dout_oe_o = q.oe;
  assign rdy_n_o = q.rdy;
  assign cread_o = q.cread;
  assign shutdown_o = q.shdn;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_pre;
    done && !ifrst ##1 q.rdy && q.pend;
  endsequence

  sequence s_store;
    q.pend && !acc_data && !ifrst ##1 !q.rdy;
  endsequence

  AST_SINGLE_OFF: assert property (
    done && md == MD_SINGLE && !mode_wr && !ifrst |=> q.cv == CV_OFF)
    else $error("single conversion did not return to shutdown");

  AST_SETTLE_TWO: assert property (
    done && q.cv == CV_SETTLE |-> q.per)
    else $error("settling ended before two periods");

  AST_PRE_HIGH: assert property (
    done && !ifrst |-> s_pre)
    else $error("ready not raised before update");

  AST_RDY_LOW: assert property (
    q.pend && !acc_data && !ifrst |-> s_store)
    else $error("ready not low after result stored");

  AST_READ_HIGH: assert property (
    rd_end && q.tgt == RS_DATA && !(q.pend && q.cread) |=> q.rdy)
    else $error("ready not high after full read");

  AST_DISCARD: assert property (
    q.pend && acc_data && !q.cread && !ifrst |=> $stable(q.data))
    else $error("result overwrote data during access");

  AST_CREAD_ON: assert property (
    cmd_on && !ifrst |=> q.cread)
    else $error("continuous read not entered");

  AST_CREAD_OFF: assert property (
    cmd_off |=> !q.cread)
    else $error("continuous read not left");

  AST_CREAD_LOAD: assert property (
    q.pend && q.cread && !ifrst |=> q.ph == PH_RD && q.bits == 6'h00)
    else $error("new result not loaded in continuous read");

  AST_IF_RESET: assert property (
    ifrst |=> q.mode == MODE_POR && !q.cread && q.ph == PH_COMM)
    else $error("ones run did not reset interface");

endmodule : adc_conv_readout

`default_nettype wire

//--- bench/host_model.sv
// Purpose: serial host that drives the converter's link pins
// Assumes: clock idles high, data changed on fall, sampled before rise
// Notes: one bit takes 21 system clocks, a 168 ns link period
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic dout_rdy_i,
  output logic sclk_o,
  output logic din_o,
  output logic cs_n_o
);
  initial
  begin
    sclk_o = 1'b1;
    din_o = 1'b0;
    cs_n_o = 1'b0;
  end
  task set_cs(input logic v);
    @(posedge clk_i);
    cs_n_o <= v;
  endtask : set_cs
  // Shift n bits MSB first, gather the answer
  task xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge clk_i);
      sclk_o <= 1'b0;
      din_o <= tx[i];
      repeat (10) @(posedge clk_i);
      rx = {rx[30:0], dout_rdy_i};
      sclk_o <= 1'b1;
      repeat (10) @(posedge clk_i);
    end
    din_o <= 1'b0;
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- bench/tb.sv
// Purpose: self-checking bench of the conversion and readout block
// Assumes: 16-bit result, short conversion period
// Notes: reads finish before the next completion, except the one that s_unip overlaps with it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_ctrl_pkg::*;
  localparam int W = 16;
  localparam int CONV = 1200;
  logic clk_i;
  logic rst_i;
  logic [W-1:0] sample_i;
  wire logic sclk, din, cs_n, dout, oe, rdy_n, cread, shdn;
  int errors;
  int n_checks;
  int c;
  logic [31:0] rx;
  logic [W-1:0] d;
  adc_conv_readout #(.RES_W(W), .CONV_CYCLES(CONV)) adc_conv_readout_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .din_i(din),
    .cs_n_i(cs_n), .sample_i(sample_i), .dout_rdy_o(dout),
    .dout_oe_o(oe), .rdy_n_o(rdy_n), .cread_o(cread), .shutdown_o(shdn));
  host_model host_model_inst (.clk_i(clk_i), .dout_rdy_i(dout),
    .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));
  ////////////////////////////////////////////////////////////////////
  task check(input string s, input logic [31:0] seen, input logic [31:0] e);
    n_checks++;
    if (seen !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, seen);
    end
  endtask : check
  task end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task wait_rdy(input logic v);
    c = 0;
    while (rdy_n !== v && c < 3 * CONV)
    begin
      @(posedge clk_i);
      c++;
    end
    check("rdy wait", rdy_n, v);
  endtask : wait_rdy
  task rd_data;
    host_model_inst.xfer(32'h38, 8, rx);
    host_model_inst.xfer(32'h0, W, rx);
    d = rx[W-1:0];
  endtask : rd_data
  task wr_mode(input logic [7:0] m);
    host_model_inst.xfer(32'h10, 8, rx);
    host_model_inst.xfer({24'h0, m}, 8, rx);
  endtask : wr_mode
  ////////////////////////////////////////////////////////////////////
  task s_reset;
    check("rdy_n", rdy_n, 1);
    check("cread", cread, 0);
    check("shdn", shdn, 0);
    check("dout", dout, 1);
    host_model_inst.set_cs(1'b1);
    repeat (6) @(posedge clk_i);
    check("oe off", oe, 0);
    host_model_inst.set_cs(1'b0);
    repeat (6) @(posedge clk_i);
    check("oe on", oe, 1);
  endtask : s_reset
  task s_cont;
    sample_i <= 16'h1234;
    wait_rdy(1'b0);
    repeat (3) @(posedge clk_i);
    check("dout low", dout, 0);
    rd_data();
    check("data", d, 16'h9234);
    check("dout hi", dout, 1);
    rd_data();
    check("reread", d, 16'h9234);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    host_model_inst.xfer(32'h08, 8, rx);
    host_model_inst.xfer(32'h0, 8, rx);
    check("status", rx[7:0], 8'h08);
    rd_data();
    check("rdy after", rdy_n, 1);
  endtask : s_cont
  task s_unip;
    wr_mode(8'h06);
    sample_i <= 16'h8000;
    wait_rdy(1'b0);
    rd_data();
    check("uni neg", d, 16'h0000);
    sample_i <= 16'h7fff;
    wait_rdy(1'b0);
    rd_data();
    check("uni full", d, 16'hffff);
    sample_i <= 16'h0100;
    wait_rdy(1'b0);
    repeat (CONV - 300) @(posedge clk_i);
    sample_i <= 16'h0200;
    rd_data();
    check("lost data", d, 16'h0200);
    check("lost rdy", rdy_n, 1);
  endtask : s_unip
  task s_single;
    wr_mode(8'hc2);
    repeat (5) @(posedge clk_i);
    check("pdn", shdn, 1);
    wr_mode(8'h82);
    sample_i <= 16'h0000;
    check("awake", shdn, 0);
    wait_rdy(1'b0);
    check("conv time", (c >= 2370 && c <= 2430), 1);
    repeat (5) @(posedge clk_i);
    check("shdn", shdn, 1);
    rd_data();
    check("bip mid", d, 16'h8000);
    c = 0;
    repeat (3 * CONV)
    begin
      @(posedge clk_i);
      c += (rdy_n !== 1'b1 || dout !== 1'b1);
    end
    check("stay hi", c, 0);
    rd_data();
    check("reread", d, 16'h8000);
  endtask : s_single
  task s_cread;
    wr_mode(8'h06);
    host_model_inst.xfer(32'h3c, 8, rx);
    repeat (5) @(posedge clk_i);
    check("cread on", cread, 1);
    sample_i <= 16'h4000;
    wait_rdy(1'b0);
    host_model_inst.xfer(32'h0, W, rx);
    check("cr data", rx[W-1:0], 16'h8000);
    check("cr rdy", rdy_n, 1);
    sample_i <= 16'h2000;
    wait_rdy(1'b0);
    sample_i <= 16'h1000;
    host_model_inst.xfer(32'h0, 4, rx);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    host_model_inst.xfer(32'h0, W, rx);
    check("cr new", rx[W-1:0], 16'h2000);
    check("cr kept", cread, 1);
    wait_rdy(1'b0);
    host_model_inst.xfer(32'h38, 8, rx);
    repeat (5) @(posedge clk_i);
    check("cread off", cread, 0);
  endtask : s_cread
  task s_ones;
    host_model_inst.xfer(32'h3c, 8, rx);
    host_model_inst.xfer(32'hffff_ffff, 32, rx);
    repeat (5) @(posedge clk_i);
    check("ones cr", cread, 0);
    check("ones rdy", rdy_n, 1);
    sample_i <= 16'h0000;
    wait_rdy(1'b0);
    rd_data();
    check("por mode", d, 16'h8000);
  endtask : s_ones
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (80000) @(posedge clk_i);
    errors++;
    end_sim();
  end
  initial
  begin
    errors = 0;
    n_checks = 0;
    rst_i = 1'b1;
    sample_i = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    s_reset();
    s_cont();
    s_unip();
    s_single();
    s_cread();
    s_ones();
    end_sim();
  end
endmodule : tb
`default_nettype wire
